// file: logic/ltsc_pkg.sv
// package for the long-mode task state checks block
// assumes a core that presents control transfers as one-cycle requests
package ltsc_pkg;
  // ---------------------------------------------------------------
  // task state record layout (byte offsets from record base)
  // ---------------------------------------------------------------
  localparam logic [7:0] LTSC_OFF_STACK0 = 8'h04;
  localparam logic [7:0] LTSC_OFF_STACK1 = 8'h0c;
  localparam logic [7:0] LTSC_OFF_STACK2 = 8'h14;
  localparam logic [7:0] LTSC_OFF_ALT1 = 8'h24;
  localparam logic [7:0] LTSC_ALT_STRIDE = 8'h08;
  localparam logic [7:0] LTSC_OFF_IOMAP = 8'h64;
  localparam logic [7:0] LTSC_HALF_STRIDE = 8'h04;
  localparam int LTSC_IOMAP_POS = 16;
  localparam logic [2:0] LTSC_ALT_LAST = 3'h7;
  localparam logic [1:0] LTSC_PRIV_LAST = 2'h2;
  localparam logic [63:0] LTSC_RST_BASE = 64'h0;
  localparam logic [1:0] LTSC_RST_PRIV = 2'h0;

  // ---------------------------------------------------------------
  // kinds of control transfer seen by the checker
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LTSC_XFER_JUMP,
    LTSC_XFER_CALL,
    LTSC_XFER_SOFT_INT,
    LTSC_XFER_HW_INT,
    LTSC_XFER_INTERRUPT_RETURN_INSN,
    LTSC_XFER_OTHER
  } ltsc_xfer_e;

  // target descriptor classes
  typedef enum logic [1:0] {
    LTSC_TGT_PLAIN,
    LTSC_TGT_RECORD,
    LTSC_TGT_TASK_GATE
  } ltsc_tgt_e;
endpackage

// file: logic/ltsc_mem_if.sv
// interface between the checker and its record fetch engine
// assumes both ends share i_sys_clk
`timescale 1ns/1ps
interface ltsc_mem_if;
  logic start;
  logic [63:0] addr;
  logic busy;
  logic done;
  logic [63:0] data;
  logic [15:0] iomap_off;
  logic want_iomap;
  modport ctl (output start, output addr, output want_iomap,
               input busy, input done, input data, input iomap_off);
  modport eng (input start, input addr, input want_iomap,
               output busy, output done, output data, output iomap_off);
endinterface

// file: logic/ltsc_fetch.sv
// two-word fetch engine for task state record fields, one word for the permission map offset
// assumes a memory port that answers each read with a one-cycle valid
`timescale 1ns/1ps
module ltsc_fetch
  import ltsc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  ltsc_mem_if.eng mi,
  output logic o_rd_req,
  output logic [63:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data
);
  typedef enum logic [1:0] {LTSC_F_IDLE, LTSC_F_LOW, LTSC_F_HIGH} ltsc_fst_e;
  ltsc_fst_e st_reg, st_next;
  logic [31:0] low_reg, low_next;
  logic [63:0] addr_reg, addr_next;
  logic [63:0] data_reg, data_next;
  logic iom_reg, iom_next;
  logic done_reg, done_next;

  always_comb begin
    st_next = st_reg;
    low_next = low_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    iom_next = iom_reg;
    done_next = 1'b0;
    case (st_reg)
      LTSC_F_IDLE: begin
        if (mi.start) begin
          addr_next = mi.addr;
          iom_next = mi.want_iomap;
          st_next = LTSC_F_LOW;
        end
      end
      LTSC_F_LOW: begin
        if (i_rd_valid) begin
          low_next = i_rd_data;
          if (iom_reg) begin
            data_next = {32'h0, i_rd_data};
            done_next = 1'b1;
            st_next = LTSC_F_IDLE;
          end else begin
            addr_next = addr_reg + {56'h0, LTSC_HALF_STRIDE};
            st_next = LTSC_F_HIGH;
          end
        end
      end
      LTSC_F_HIGH: begin
        if (i_rd_valid) begin
          data_next = {i_rd_data, low_reg};
          done_next = 1'b1;
          st_next = LTSC_F_IDLE;
        end
      end
      default: st_next = LTSC_F_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= LTSC_F_IDLE;
      low_reg <= 32'h0;
      addr_reg <= 64'h0;
      data_reg <= 64'h0;
      iom_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      low_reg <= low_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      iom_reg <= iom_next;
      done_reg <= done_next;
    end
  end

  assign o_rd_req = (st_reg != LTSC_F_IDLE);
  assign o_rd_addr = addr_reg;
  assign mi.busy = (st_reg != LTSC_F_IDLE);
  assign mi.done = done_reg;
  assign mi.data = data_reg;
  assign mi.iomap_off = data_reg[LTSC_IOMAP_POS +: 16];
endmodule // ltsc_fetch

// file: logic/ltsc_top.sv
// long-mode task handling checks and task state record lookups
// assumes the core decodes transfers and gives one-cycle requests
// Operation
// - in 64-bit mode a jump, call, soft or hard interrupt to a record or task gate faults.
// - in 64-bit mode an interrupt return with the nested task flag set faults.
// - in 64-bit mode no hardware task switch happens, no state is saved or loaded.
// - the record gives a 64-bit stack pointer for each privilege level 0 to 2.
// - the record gives alternate stack entries one through seven for selection.
// - the permission map address is record base plus a 16-bit offset from the record.
// - each 64-bit pointer is two 32-bit halves joined low then high.
// - the task register loaded in 64-bit mode serves both 64-bit and compat code.
`timescale 1ns/1ps
module ltsc_top
  import ltsc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_long_mode,
  input wire logic i_xfer_valid,
  input wire ltsc_pkg::ltsc_xfer_e i_xfer_kind,
  input wire ltsc_pkg::ltsc_tgt_e i_xfer_target,
  input wire logic i_nested_task_flag,
  output logic o_general_protection_fault,
  output logic o_xfer_accept,
  output logic o_task_switch,
  input wire logic i_load_task_register_insn,
  input wire logic [63:0] i_task_register_base,
  input wire logic i_stack_req,
  input wire logic [1:0] i_stack_priv,
  input wire logic [2:0] i_alt_sel,
  input wire logic i_iomap_req,
  output logic o_lookup_busy,
  output logic o_lookup_done,
  output logic [63:0] o_lookup_value,
  output logic o_lookup_err,
  output logic o_rd_req,
  output logic [63:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data
);
  ltsc_mem_if mi ();

  // ---------------------------------------------------------------
  // transfer checks
  // ---------------------------------------------------------------
  function automatic logic is_gate_xfer(input ltsc_xfer_e k);
    is_gate_xfer = (k == LTSC_XFER_JUMP) || (k == LTSC_XFER_CALL) ||
                   (k == LTSC_XFER_SOFT_INT) || (k == LTSC_XFER_HW_INT);
  endfunction

  logic fault_reg, fault_next;
  logic acc_reg, acc_next;
  logic sw_reg, sw_next;

  always_comb begin
    fault_next = 1'b0;
    acc_next = 1'b0;
    sw_next = 1'b0;
    if (i_xfer_valid) begin
      if (i_long_mode && is_gate_xfer(i_xfer_kind) &&
          (i_xfer_target != LTSC_TGT_PLAIN)) begin
        fault_next = 1'b1;
      end else if (i_long_mode && (i_xfer_kind == LTSC_XFER_INTERRUPT_RETURN_INSN) &&
                   i_nested_task_flag) begin
        fault_next = 1'b1;
      end else begin
        acc_next = 1'b1;
      end
      // outside long mode a record target still means a hardware switch
      sw_next = !i_long_mode && is_gate_xfer(i_xfer_kind) &&
                (i_xfer_target != LTSC_TGT_PLAIN);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_reg <= 1'b0;
      acc_reg <= 1'b0;
      sw_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      acc_reg <= acc_next;
      sw_reg <= sw_next;
    end
  end

  assign o_general_protection_fault = fault_reg;
  assign o_xfer_accept = acc_reg;
  assign o_task_switch = sw_reg;

  // ---------------------------------------------------------------
  // task register base cache
  // ---------------------------------------------------------------
  logic [63:0] base_reg, base_next;
  logic loaded_reg, loaded_next;

  always_comb begin
    base_next = base_reg;
    loaded_next = loaded_reg;
    if (i_load_task_register_insn && i_long_mode) begin
      base_next = i_task_register_base;
      loaded_next = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      base_reg <= LTSC_RST_BASE;
      loaded_reg <= 1'b0;
    end else begin
      base_reg <= base_next;
      loaded_reg <= loaded_next;
    end
  end

  // ---------------------------------------------------------------
  // record lookups
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LTSC_L_IDLE, LTSC_L_WAIT, LTSC_L_IOMAP} ltsc_lst_e;
  ltsc_lst_e lst_reg, lst_next;
  logic start_next;
  logic [63:0] addr_next;
  logic iom_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic [63:0] val_reg, val_next;
  logic [7:0] field_off;

  always_comb begin
    field_off = 8'h0;
    if (i_alt_sel != 3'h0) begin
      field_off = LTSC_OFF_ALT1 + 8'(({5'h0, i_alt_sel} - 8'h1) * LTSC_ALT_STRIDE);
    end else begin
      case (i_stack_priv)
        2'h0: field_off = LTSC_OFF_STACK0;
        2'h1: field_off = LTSC_OFF_STACK1;
        default: field_off = LTSC_OFF_STACK2;
      endcase
    end
  end

  always_comb begin
    lst_next = lst_reg;
    start_next = 1'b0;
    addr_next = 64'h0;
    iom_next = 1'b0;
    done_next = 1'b0;
    err_next = 1'b0;
    val_next = val_reg;
    case (lst_reg)
      LTSC_L_IDLE: begin
        if (i_stack_req || i_iomap_req) begin
          if (!loaded_reg || (i_stack_req && i_alt_sel == 3'h0 &&
                              i_stack_priv > LTSC_PRIV_LAST)) begin
            err_next = 1'b1;
            done_next = 1'b1;
          end else if (i_stack_req) begin
            start_next = 1'b1;
            addr_next = base_reg + {56'h0, field_off};
            lst_next = LTSC_L_WAIT;
          end else begin
            start_next = 1'b1;
            iom_next = 1'b1;
            addr_next = base_reg + {56'h0, LTSC_OFF_IOMAP};
            lst_next = LTSC_L_IOMAP;
          end
        end
      end
      LTSC_L_WAIT: begin
        if (mi.done) begin
          val_next = mi.data;
          done_next = 1'b1;
          lst_next = LTSC_L_IDLE;
        end
      end
      LTSC_L_IOMAP: begin
        if (mi.done) begin
          val_next = base_reg + {48'h0, mi.iomap_off};
          done_next = 1'b1;
          lst_next = LTSC_L_IDLE;
        end
      end
      default: lst_next = LTSC_L_IDLE;
    endcase
  end

  logic start_reg;
  logic [63:0] addr_reg;
  logic iom_reg;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lst_reg <= LTSC_L_IDLE;
      start_reg <= 1'b0;
      addr_reg <= 64'h0;
      iom_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      val_reg <= 64'h0;
    end else begin
      lst_reg <= lst_next;
      start_reg <= start_next;
      addr_reg <= addr_next;
      iom_reg <= iom_next;
      done_reg <= done_next;
      err_reg <= err_next;
      val_reg <= val_next;
    end
  end

  assign mi.start = start_reg;
  assign mi.addr = addr_reg;
  assign mi.want_iomap = iom_reg;
  assign o_lookup_busy = (lst_reg != LTSC_L_IDLE);
  assign o_lookup_done = done_reg;
  assign o_lookup_value = val_reg;
  assign o_lookup_err = err_reg;

  ltsc_fetch u_fetch (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .mi(mi.eng),
    .o_rd_req(o_rd_req),
    .o_rd_addr(o_rd_addr),
    .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data)
  );
endmodule // ltsc_top

// file: bench/ltsc_top_props.sv
// assertions on the task checks block ports
// assumes the bench answers reads and a single clock domain
`timescale 1ns/1ps
module ltsc_props
  import ltsc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_long_mode,
  input wire logic i_xfer_valid,
  input wire ltsc_pkg::ltsc_xfer_e i_xfer_kind,
  input wire ltsc_pkg::ltsc_tgt_e i_xfer_target,
  input wire logic i_nested_task_flag,
  input wire logic o_general_protection_fault,
  input wire logic o_xfer_accept,
  input wire logic o_task_switch,
  input wire logic o_lookup_busy,
  input wire logic i_stack_req,
  input wire logic o_lookup_done,
  input wire logic o_lookup_err,
  input wire logic o_rd_req,
  input wire logic [63:0] o_rd_addr,
  input wire logic i_rd_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic gate_hit;
  assign gate_hit = i_xfer_valid && i_long_mode && i_xfer_kind != LTSC_XFER_INTERRUPT_RETURN_INSN
    && i_xfer_kind != LTSC_XFER_OTHER && i_xfer_target != LTSC_TGT_PLAIN;
  AST_GPF_GATE: assert property (gate_hit |=> o_general_protection_fault)
    else $error("no fault on task target");
  AST_GPF_INTERRUPT_RETURN_INSN: assert property (i_xfer_valid && i_long_mode && i_xfer_kind == LTSC_XFER_INTERRUPT_RETURN_INSN
    && i_nested_task_flag |=> o_general_protection_fault)
    else $error("no fault on nested return");
  AST_INTERRUPT_RETURN_INSN_OK: assert property (i_xfer_valid && i_long_mode && i_xfer_kind == LTSC_XFER_INTERRUPT_RETURN_INSN
    && !i_nested_task_flag |=> o_xfer_accept)
    else $error("plain return refused");
  AST_NO_SWITCH: assert property (i_xfer_valid && i_long_mode |=> !o_task_switch)
    else $error("task switch in long mode");
  AST_ONE_ANSWER: assert property (i_xfer_valid |=> o_general_protection_fault ^ o_xfer_accept)
    else $error("not exactly one answer");
  AST_QUIET: assert property (!i_xfer_valid |=> !o_general_protection_fault && !o_xfer_accept)
    else $error("answer without transfer");
  AST_RD_HOLD: assert property (o_rd_req && !i_rd_valid |=> o_rd_req && $stable(o_rd_addr))
    else $error("read dropped before answer");
  AST_DONE: assert property (!o_lookup_busy && i_stack_req |-> ##[1:80] o_lookup_done)
    else $error("lookup never done");
  AST_ERR_DONE: assert property (o_lookup_err |-> o_lookup_done)
    else $error("error without done");
  CV_GPF: cover property (gate_hit ##1 o_general_protection_fault);
  CV_ERR: cover property (o_lookup_err);
  CV_STALL: cover property (o_rd_req && !i_rd_valid ##1 o_rd_req);
endmodule // ltsc_props

bind ltsc_top ltsc_props u_props (
  .i_sys_clk(i_sys_clk),
  .i_arst_n(i_arst_n),
  .i_long_mode(i_long_mode),
  .i_xfer_valid(i_xfer_valid),
  .i_xfer_kind(i_xfer_kind),
  .i_xfer_target(i_xfer_target),
  .i_nested_task_flag(i_nested_task_flag),
  .o_general_protection_fault(o_general_protection_fault),
  .o_xfer_accept(o_xfer_accept),
  .o_task_switch(o_task_switch),
  .o_lookup_busy(o_lookup_busy),
  .i_stack_req(i_stack_req),
  .o_lookup_done(o_lookup_done),
  .o_lookup_err(o_lookup_err),
  .o_rd_req(o_rd_req),
  .o_rd_addr(o_rd_addr),
  .i_rd_valid(i_rd_valid)
);

// file: bench/long_mode_task_state_checks_tb_top.sv
// self-checking bench for the task checks block
// assumes the bench plays the memory behind the read port
`timescale 1ns/1ps
module long_mode_task_state_checks_tb_top;
  import ltsc_pkg::*;
  logic i_sys_clk = 0, i_arst_n = 0, i_long_mode = 0, i_xfer_valid = 0, i_nested_task_flag = 0;
  ltsc_xfer_e i_xfer_kind = LTSC_XFER_OTHER;
  ltsc_tgt_e i_xfer_target = LTSC_TGT_PLAIN;
  logic i_load_task_register_insn = 0, i_stack_req = 0, i_iomap_req = 0, i_rd_valid = 0;
  logic [63:0] i_task_register_base = '0, o_lookup_value, o_rd_addr;
  logic [1:0] i_stack_priv = '0;
  logic [2:0] i_alt_sel = '0;
  logic [31:0] i_rd_data = '0;
  logic o_general_protection_fault, o_xfer_accept, o_task_switch;
  logic o_lookup_busy, o_lookup_done, o_lookup_err, o_rd_req;
  int n_mismatch = 0, checked = 0;
  logic [63:0] base;
  ltsc_top dut_u (.*);
  initial forever #5 i_sys_clk = ~i_sys_clk;
  // ---------------------------------------------------------------
  // memory model, random stalls
  // ---------------------------------------------------------------
  function automatic logic [31:0] mem_f(input logic [63:0] a);
    return a[31:0] ^ 32'h5a5a_0f0f ^ {a[47:32], 16'h0};
  endfunction
  always @(posedge i_sys_clk) begin
    i_rd_valid <= o_rd_req && !i_rd_valid && ($urandom % 2 == 0);
    i_rd_data <= mem_f(o_rd_addr);
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input int k, input int t, input logic nt, input logic lm);
    logic f;
    f = lm && ((k <= 3 && t != 0) || (k == 4 && nt));
    @(posedge i_sys_clk);
    i_xfer_valid <= 1;
    i_xfer_kind <= ltsc_xfer_e'(k);
    i_xfer_target <= ltsc_tgt_e'(t);
    i_nested_task_flag <= nt;
    i_long_mode <= lm;
    @(posedge i_sys_clk);
    i_xfer_valid <= 0;
    #1;
    chk("fault", f, o_general_protection_fault);
    chk("accept", !f, o_xfer_accept);
    chk("switch", !lm && k <= 3 && t != 0, o_task_switch);
  endtask
  task automatic look(input logic io, input logic [1:0] p, input logic [2:0] a, input logic er);
    logic [63:0] ad, ev;
    int n;
    ad = base + (a != 0 ? 64'h24 + (a - 1) * 8 : 64'h04 + p * 8);
    ev = io ? base + (mem_f(base + 64'h64) >> 16) : {mem_f(ad + 4), mem_f(ad)};
    @(posedge i_sys_clk);
    i_stack_req <= !io;
    i_iomap_req <= io;
    i_stack_priv <= p;
    i_alt_sel <= a;
    @(posedge i_sys_clk);
    i_stack_req <= 0;
    i_iomap_req <= 0;
    #1;
    chk("busy", !er, o_lookup_busy);
    n = 0;
    while (o_lookup_done !== 1'b1 && n < 80) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("done", 1, o_lookup_done);
    chk("idle", 0, o_lookup_busy);
    chk("err", er, o_lookup_err);
    if (!er) chk("value", ev, o_lookup_value);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial begin
    void'($urandom(32'ha23a));
    repeat (3) @(posedge i_sys_clk);
    chk("reset", 0, {o_general_protection_fault, o_xfer_accept, o_task_switch,
                     o_lookup_done, o_lookup_busy, o_rd_req});
    i_arst_n <= 1;
    for (int k = 0; k < 6; k++)
      for (int t = 0; t < 3; t++) xfer(k, t, 1, 1);
    repeat (150) xfer($urandom % 6, $urandom % 3, $urandom % 2, $urandom % 2);
    base = 0;
    i_long_mode <= 1;
    look(0, 0, 0, 1);
    base = {$urandom, $urandom};
    @(posedge i_sys_clk);
    i_load_task_register_insn <= 1;
    i_task_register_base <= base;
    @(posedge i_sys_clk);
    i_load_task_register_insn <= 0;
    for (int i = 0; i < 11; i++) begin
      i_long_mode <= 1'($urandom % 2);
      if (i < 3) look(0, i, 0, 0);
      else if (i < 10) look(0, $urandom % 4, i - 2, 0);
      else look(1, 0, 0, 0);
    end
    look(0, 3, 0, 1);
    close_out;
  end
endmodule // long_mode_task_state_checks_tb_top
